// ===== swpm_engine.v
`include "swpm_regs.vh"

module swpm_engine (
	input  wire                       pclk,
	input  wire                       presetn,
	input  wire [`SWPM_SAMPLE_W-1:0]  sample_i,
	input  wire [`SWPM_SAMPLE_W-1:0]  sample_q,
	input  wire [6:0]                 period,
	input  wire [1:0]                 len_exp,
	input  wire                       mon_on,
	input  wire [`SWPM_LIMIT_W-1:0]   limit,
	output reg  [`SWPM_POWER_W-1:0]   power_q,
	output reg                        err_q
);

	reg  [6:0]               div_q;
	reg  [3:0]               win_q;
	reg  [`SWPM_ACC_W-1:0]   acc_q;

	wire signed [5:0]        top_i;
	wire signed [5:0]        top_q;
	wire signed [11:0]       sq_i;
	wire signed [11:0]       sq_q;
	wire [`SWPM_POWER_W-1:0] inst_pw;
	wire [`SWPM_ACC_W-1:0]   sum_w;
	wire [`SWPM_ACC_W-1:0]   avg_w;
	wire                     tick;
	wire                     last;

	assign top_i   = sample_i[`SWPM_SAMPLE_W-1 -: `SWPM_TOP_BITS];
	assign top_q   = sample_q[`SWPM_SAMPLE_W-1 -: `SWPM_TOP_BITS];
	assign sq_i    = top_i * top_i;
	assign sq_q    = top_q * top_q;
	// Both squares are at most 1024, so the sum fits in 12 bits
	assign inst_pw = sq_i + sq_q;

	// Period of zero behaves as one tick per cycle
	assign tick  = ({1'b0, div_q} + 8'h01) >= {1'b0, period};
	assign last  = win_q >= ((4'h1 << len_exp) - 4'h1);
	assign sum_w = acc_q + {3'h0, inst_pw};
	assign avg_w = sum_w >> len_exp;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q   <= 7'h00;
			win_q   <= 4'h0;
			acc_q   <= {`SWPM_ACC_W{1'b0}};
			power_q <= {`SWPM_POWER_W{1'b0}};
			err_q   <= 1'b0;
		end else begin
			err_q <= 1'b0;
			if (tick) begin
				div_q <= 7'h00;
				if (last) begin
					acc_q   <= {`SWPM_ACC_W{1'b0}};
					win_q   <= 4'h0;
					power_q <= avg_w[`SWPM_POWER_W-1:0];
					err_q   <= mon_on && ({1'b0, avg_w[`SWPM_POWER_W-1:0]} > limit);
				end else begin
					acc_q <= sum_w;
					win_q <= win_q + 4'h1;
				end
			end else begin
				div_q <= div_q + 7'h01;
			end
		end
	end

endmodule

// ===== swpm_regs.vh
`ifndef SWPM_REGS_VH
`define SWPM_REGS_VH

// Register indexes; byte address is four times the index
`define SWPM_IDX_PAGE      11'h008
`define SWPM_IDX_THR_LO    11'h588
`define SWPM_IDX_THR_HI    11'h589
`define SWPM_IDX_CTRL      11'h58A
`define SWPM_IDX_PWR_LO    11'h58B
`define SWPM_IDX_IRQ_STAT  11'h590
`define SWPM_IDX_IRQ_MASK  11'h591

// Field positions
`define SWPM_PAGE_MSB      1
`define SWPM_THR_HI_MSB    4
`define SWPM_CTRL_EN_BIT   7
`define SWPM_CTRL_LEN_MSB  1

// Reset values
`define SWPM_PAGE_RST      2'h3
`define SWPM_THR_LO_RST    8'h00
`define SWPM_THR_HI_RST    5'h00
`define SWPM_CTRL_EN_RST   1'b0
`define SWPM_CTRL_LEN_RST  2'h0
`define SWPM_STAT_RST      2'h0
`define SWPM_MASK_RST      2'h0

// Monitor clock period in DAC clock periods
`define SWPM_PER_MAIN_MUL  7'h04
`define SWPM_PER_CHAN_MUL  7'h08
`define SWPM_PER_DEFAULT   7'h20

// Widths
`define SWPM_NUM_PATHS     2
`define SWPM_SAMPLE_W      16
`define SWPM_TOP_BITS      6
`define SWPM_POWER_W       12
`define SWPM_LIMIT_W       13
`define SWPM_ACC_W         15

`endif

// ===== swpm_src.sv
module swpm_src (
	input  logic        pclk,
	input  logic [5:0]  top_i,
	input  logic [5:0]  top_q,
	output logic [15:0] i0,
	output logic [15:0] q0,
	output logic [15:0] i1,
	output logic [15:0] q1
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] junk = 10'h000;
	// Low bits churn so any use of them shows in the power
	always @(posedge pclk) junk <= junk + 10'h0a7;
	assign i0 = {top_i, junk};
	assign q0 = {top_q, ~junk};
	assign i1 = {top_q, junk};
	assign q1 = {top_i, ~junk};
endmodule

// ===== swpm_top.v
// The implementer's own choice: the APB interface to the registers.
`include "swpm_regs.vh"

// Summary of operation
// - Average compared with 13-bit limit; bits 12:8 high register, 7:0 low.
// - Paged register accesses go to datapaths chosen by the page select field.
// - Error detection works only while control bit 7 is set; resets off.
// - Averaging window is two to the power of the length field, in ticks.
// - Main interpolation above one: tick period is 4 times main factor.
// - Channel interpolation above one: tick period is 8 times main factor.
// - Otherwise tick period is 32 DAC clock periods.
// - Power is I squared plus Q squared from six top bits each.
// - Average power readable; low eight bits in readback register.
module swpm_top (
	input  wire                       pclk,
	input  wire                       presetn,
	input  wire                       psel,
	input  wire                       penable,
	input  wire                       pwrite,
	input  wire [12:0]                paddr,
	input  wire [31:0]                pwdata,
	output reg  [31:0]                prdata_q,
	output reg                        pready_q,
	output reg                        pslverr_q,
	input  wire [3:0]                 main_interp,
	input  wire [3:0]                 chan_interp,
	input  wire [`SWPM_SAMPLE_W-1:0]  path0_i,
	input  wire [`SWPM_SAMPLE_W-1:0]  path0_q,
	input  wire [`SWPM_SAMPLE_W-1:0]  path1_i,
	input  wire [`SWPM_SAMPLE_W-1:0]  path1_q,
	output reg                        irq_q
);

	localparam NP = `SWPM_NUM_PATHS;

	reg  [1:0]                datapath_page_select_q;
	reg  [7:0]                thr_lo_q [0:NP-1];
	reg  [4:0]                thr_hi_q [0:NP-1];
	reg  [NP-1:0]             mon_on_q;
	reg  [1:0]                len_q    [0:NP-1];
	reg  [NP-1:0]             stat_q;
	reg  [NP-1:0]             mask_q;
	reg  [6:0]                period_q;
	reg  [6:0]                period_d;
	reg  [31:0]               rdata_d;
	reg                       hit_d;
	reg                       rd_page;

	wire [10:0]               idx;
	wire                      wr_en;
	wire                      setup;
	wire [`SWPM_POWER_W-1:0]  power   [0:NP-1];
	wire [NP-1:0]             err_evt;
	wire [`SWPM_SAMPLE_W-1:0] samp_i  [0:NP-1];
	wire [`SWPM_SAMPLE_W-1:0] samp_q  [0:NP-1];

	assign idx   = paddr[12:2];
	assign setup = psel && !penable;
	// Write lands only at the completing access edge
	assign wr_en = psel && penable && pready_q && pwrite;

	assign samp_i[0] = path0_i;
	assign samp_q[0] = path0_q;
	assign samp_i[1] = path1_i;
	assign samp_q[1] = path1_q;

	// Interpolation settings come from same-clock logic
	always @* begin
		if (main_interp > 4'h1) begin
			period_d = `SWPM_PER_MAIN_MUL * {3'h0, main_interp};
		end else if (chan_interp > 4'h1) begin
			period_d = `SWPM_PER_CHAN_MUL * {3'h0, main_interp};
		end else begin
			period_d = `SWPM_PER_DEFAULT;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_q <= `SWPM_PER_DEFAULT;
		end else begin
			period_q <= period_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			datapath_page_select_q <= `SWPM_PAGE_RST;
			mask_q                 <= `SWPM_MASK_RST;
		end else if (wr_en) begin
			if (idx == `SWPM_IDX_PAGE) begin
				datapath_page_select_q <= pwdata[`SWPM_PAGE_MSB:0];
			end
			if (idx == `SWPM_IDX_IRQ_MASK) begin
				mask_q <= pwdata[NP-1:0];
			end
		end
	end

	genvar p;
	generate
		for (p = 0; p < NP; p = p + 1) begin : g_path
			wire sel_w;

			// Writes reach every datapath whose page bit is set
			assign sel_w = wr_en && datapath_page_select_q[p];

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					thr_lo_q[p] <= `SWPM_THR_LO_RST;
					thr_hi_q[p] <= `SWPM_THR_HI_RST;
					mon_on_q[p] <= `SWPM_CTRL_EN_RST;
					len_q[p]    <= `SWPM_CTRL_LEN_RST;
				end else if (sel_w) begin
					if (idx == `SWPM_IDX_THR_LO) begin
						thr_lo_q[p] <= pwdata[7:0];
					end
					if (idx == `SWPM_IDX_THR_HI) begin
						thr_hi_q[p] <= pwdata[`SWPM_THR_HI_MSB:0];
					end
					if (idx == `SWPM_IDX_CTRL) begin
						mon_on_q[p] <= pwdata[`SWPM_CTRL_EN_BIT];
						len_q[p]    <= pwdata[`SWPM_CTRL_LEN_MSB:0];
					end
				end
			end

			// New error beats a same-cycle clear
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stat_q[p] <= 1'b0;
				end else if (err_evt[p]) begin
					stat_q[p] <= 1'b1;
				end else if (wr_en && idx == `SWPM_IDX_IRQ_STAT && pwdata[p]) begin
					stat_q[p] <= 1'b0;
				end
			end

			swpm_engine u_engine (
				.pclk     (pclk),
				.presetn  (presetn),
				.sample_i (samp_i[p]),
				.sample_q (samp_q[p]),
				.period   (period_q),
				.len_exp  (len_q[p]),
				.mon_on   (mon_on_q[p]),
				.limit    ({thr_hi_q[p], thr_lo_q[p]}),
				.power_q  (power[p]),
				.err_q    (err_evt[p])
			);
		end
	endgenerate

	// Reads come from the lowest selected page; none selected reads zero
	always @* begin
		rd_page = datapath_page_select_q[0] ? 1'b0 : 1'b1;
		hit_d   = 1'b1;
		rdata_d = 32'h0000_0000;
		case (idx)
			`SWPM_IDX_PAGE: begin
				rdata_d[`SWPM_PAGE_MSB:0] = datapath_page_select_q;
			end
			`SWPM_IDX_THR_LO: begin
				if (datapath_page_select_q != 2'h0) begin
					rdata_d[7:0] = thr_lo_q[rd_page];
				end
			end
			`SWPM_IDX_THR_HI: begin
				if (datapath_page_select_q != 2'h0) begin
					rdata_d[`SWPM_THR_HI_MSB:0] = thr_hi_q[rd_page];
				end
			end
			`SWPM_IDX_CTRL: begin
				if (datapath_page_select_q != 2'h0) begin
					rdata_d[`SWPM_CTRL_EN_BIT]     = mon_on_q[rd_page];
					rdata_d[`SWPM_CTRL_LEN_MSB:0] = len_q[rd_page];
				end
			end
			`SWPM_IDX_PWR_LO: begin
				if (datapath_page_select_q != 2'h0) begin
					rdata_d[7:0] = power[rd_page][7:0];
				end
			end
			`SWPM_IDX_IRQ_STAT: begin
				rdata_d[NP-1:0] = stat_q;
			end
			`SWPM_IDX_IRQ_MASK: begin
				rdata_d[NP-1:0] = mask_q;
			end
			default: begin
				hit_d = 1'b0;
			end
		endcase
	end

	// One wait-free access phase: answer captured during setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !hit_d;
			if (setup && !pwrite) begin
				prdata_q <= rdata_d;
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

endmodule

// ===== swpm_top_chk.sv
`include "swpm_regs.vh"

module swpm_top_chk (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [12:0] paddr,
	input logic [31:0] prdata_q,
	input logic        pready_q,
	input logic        pslverr_q,
	input logic        irq_q
);
	default clocking dcb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd_ok;
	logic wr_acc;
	assign rd_ok = pready_q && !pwrite;
	// Status clears at the write edge, irq follows one edge later
	assign wr_acc = psel && penable && pwrite;
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready_q;
	endsequence
	AST_SETUP_ANS: assert property (s_setup |=> s_access) else $error("no ready");
	AST_ONE_CYCLE: assert property (pready_q |=> !pready_q) else $error("long ready");
	AST_ERR_READ: assert property (pslverr_q && !pwrite |-> s_access and
		prdata_q == 32'h0000_0000) else $error("bad error read");
	AST_PAGE_FIELD: assert property (rd_ok && paddr[12:2] == `SWPM_IDX_PAGE |->
		prdata_q[31:2] == 30'h0000_0000) else $error("page bits");
	AST_THR_FIELD: assert property (rd_ok && paddr[12:2] == `SWPM_IDX_THR_HI |->
		prdata_q[31:5] == 27'h000_0000) else $error("limit bits");
	AST_CTRL_FIELD: assert property (rd_ok && paddr[12:2] == `SWPM_IDX_CTRL |->
		(prdata_q & 32'hffff_ff7c) == 32'h0000_0000) else $error("control bits");
	AST_PWR_FIELD: assert property (rd_ok && paddr[12:2] == `SWPM_IDX_PWR_LO |->
		prdata_q[31:8] == 24'h00_0000) else $error("power bits");
	AST_IRQ_HELD: assert property ($fell(irq_q) |-> $past(wr_acc, 2))
		else $error("irq dropped");
endmodule

bind swpm_top swpm_top_chk swpm_top_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_q(prdata_q),
	.pready_q(pready_q), .pslverr_q(pslverr_q), .irq_q(irq_q));

// ===== swpm_top_test.sv
`include "swpm_regs.vh"

module swpm_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, irq_q, err;
	logic [12:0] paddr;
	logic [31:0] pwdata, prdata_q, rdata;
	logic [3:0]  main_interp, chan_interp;
	logic [5:0]  top_i, top_q;
	logic [15:0] i0, q0, i1, q1;
	int          n_fail, n_compared, e;
	// Main, channel, length field, period and sample tops per case
	int          mi[4] = '{2, 3, 1, 1};
	int          ci[4] = '{1, 1, 2, 1};
	int          ln[4] = '{0, 1, 2, 3};
	int          pd[4] = '{8, 12, 8, 32};
	logic [5:0]  si[4] = '{6'h07, 6'h38, 6'h02, 6'h06};
	logic [5:0]  sq[4] = '{6'h01, 6'h01, 6'h3e, 6'h06};

	swpm_top swpm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
		.pready_q(pready_q), .pslverr_q(pslverr_q), .main_interp(main_interp),
		.chan_interp(chan_interp), .path0_i(i0), .path0_q(q0), .path1_i(i1),
		.path1_q(q1), .irq_q(irq_q));
	swpm_src swpm_src_inst (.pclk(pclk), .top_i(top_i), .top_q(top_q), .i0(i0), .q0(q0),
		.i1(i1), .q1(q1));

	task automatic end_of_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [10:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready_q !== 1'b1);
		rdata = prdata_q;
		err = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge keeps the next setup out of this time step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [10:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d);
	endtask
	task automatic rd(input logic [10:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, '0);
		chk(rdata, exp);
	endtask

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		end_of_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		main_interp = 4'h1;
		chan_interp = 4'h1;
		top_i = 6'h03;
		top_q = 6'h04;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`SWPM_IDX_PAGE, 32'h0000_0003);
		rd(`SWPM_IDX_THR_LO, '0);
		rd(`SWPM_IDX_CTRL, '0);
		rd(`SWPM_IDX_PWR_LO, '0);
		rd(`SWPM_IDX_IRQ_MASK, '0);
		rd(11'h7ff, '0);
		chk(32'(err), 32'h0000_0001);
		wr(`SWPM_IDX_THR_HI, 32'h0000_00ff);
		rd(`SWPM_IDX_THR_HI, 32'h0000_001f);
		wr(`SWPM_IDX_THR_HI, '0);
		wr(`SWPM_IDX_THR_LO, 32'h0000_0018);
		repeat (40) @(posedge pclk);
		rd(`SWPM_IDX_PWR_LO, 32'h0000_0019);
		rd(`SWPM_IDX_IRQ_STAT, '0);
		wr(`SWPM_IDX_CTRL, 32'h0000_0080);
		repeat (40) @(posedge pclk);
		rd(`SWPM_IDX_IRQ_STAT, 32'h0000_0003);
		chk(32'(irq_q), '0);
		wr(`SWPM_IDX_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk(32'(irq_q), 32'h0000_0001);
		wr(`SWPM_IDX_THR_LO, 32'h0000_0019);
		repeat (40) @(posedge pclk);
		wr(`SWPM_IDX_IRQ_STAT, 32'h0000_0003);
		rd(`SWPM_IDX_IRQ_STAT, '0);
		chk(32'(irq_q), '0);
		for (int k = 0; k < 4; k++) begin
			main_interp <= 4'(mi[k]);
			chan_interp <= 4'(ci[k]);
			wr(`SWPM_IDX_CTRL, 32'(ln[k]));
			repeat (80) @(posedge pclk);
			top_i <= si[k];
			top_q <= sq[k];
			repeat (2 * pd[k] * (1 << ln[k]) + 4) @(posedge pclk);
			e = $signed(si[k]) * $signed(si[k]) + $signed(sq[k]) * $signed(sq[k]);
			rd(`SWPM_IDX_PWR_LO, 32'(e));
		end
		wr(`SWPM_IDX_PAGE, 32'h0000_0001);
		wr(`SWPM_IDX_THR_LO, 32'h0000_0011);
		wr(`SWPM_IDX_PAGE, 32'h0000_0002);
		rd(`SWPM_IDX_THR_LO, 32'h0000_0019);
		rd(`SWPM_IDX_PWR_LO, 32'(e));
		wr(`SWPM_IDX_PAGE, '0);
		rd(`SWPM_IDX_THR_LO, '0);
		wr(`SWPM_IDX_PAGE, 32'h0000_0001);
		rd(`SWPM_IDX_THR_LO, 32'h0000_0011);
		end_of_test();
	end
endmodule
